// [core/decu_top.sv]
// Dual event counter unit: setup registers, access ports, two channels
module decu_top
  import decu_pkg::*;
#(
  parameter int EV_NUM   = DEF_EV_NUM,
  parameter int EV_CNT_W = DEF_EV_CNT_W
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [1:0]                 cpl,
  input  wire logic                       user_read_permit,
  input  wire logic [EV_NUM*EV_CNT_W-1:0] ev_counts,
  input  wire logic                       msr_req,
  input  wire logic                       msr_wr,
  input  wire logic [1:0]                 msr_sel,
  input  wire logic [WR_W-1:0]            msr_wdata,
  output logic                            msr_ack,
  output logic                            msr_fault,
  output logic [CNT_W-1:0]                msr_rdata,
  input  wire logic                       pmc_req,
  input  wire logic                       pmc_idx,
  output logic                            pmc_ack,
  output logic                            pmc_fault,
  output logic [CNT_W-1:0]                pmc_rdata,
  output logic                            irq_req
);
  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] setup_ff [2];
  logic [CNT_W-1:0] cnt_val  [2];
  logic [1:0]       ovf_v;

  wire cpl_zero  = (cpl == 2'h0);
  wire msr_ok    = msr_req & cpl_zero;
  wire msr_bad   = msr_req & ~cpl_zero;
  wire msr_wr_ok = msr_ok & msr_wr;
  wire pmc_ok    = pmc_req & (user_read_permit | cpl_zero);
  wire pmc_bad   = pmc_req & ~pmc_ok;

  wire [CNT_W-1:0] msr_rd_mux =
      (msr_sel == SEL_SETUP_ZERO) ? CNT_W'(setup_ff[0]) :
      (msr_sel == SEL_SETUP_ONE)  ? CNT_W'(setup_ff[1]) :
      (msr_sel == SEL_COUNT_ZERO) ? cnt_val[0] : cnt_val[1];
  wire [CNT_W-1:0] pmc_rd_mux = pmc_idx ? cnt_val[1] : cnt_val[0];

  // Global enable lives in the first setup only and gates both channels
  wire glob_en = setup_ff[0][EN_BIT];
  wire [1:0] ch_run;
  assign ch_run[0] = glob_en & (setup_ff[0] != '0);
  assign ch_run[1] = glob_en & (setup_ff[1] != '0);

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  decu_ch_if chs [2] ();
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ch
      assign chs[i].cfg      = setup_ff[i];
      assign chs[i].run      = ch_run[i];
      assign chs[i].cpl_zero = cpl_zero;
      assign chs[i].wr       = msr_wr_ok & (msr_sel == (i == 0 ? SEL_COUNT_ZERO
                                                               : SEL_COUNT_ONE));
      assign chs[i].wr_data  = msr_wdata;
      assign cnt_val[i]      = chs[i].value;
      assign ovf_v[i]        = chs[i].ovf & setup_ff[i][INT_BIT];
      decu_channel #(
        .EV_NUM   (EV_NUM),
        .EV_CNT_W (EV_CNT_W)
      ) u_ch (
        .clk       (clk),
        .rst       (rst),
        .ev_counts (ev_counts),
        .ch        (chs[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_ff[0] <= SETUP_RST;
      setup_ff[1] <= SETUP_RST;
    end else if (msr_wr_ok) begin
      if (msr_sel == SEL_SETUP_ZERO) begin
        setup_ff[0] <= msr_wdata;
      end
      if (msr_sel == SEL_SETUP_ONE) begin
        setup_ff[1] <= msr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Answers and interrupt
  // ----------------------------------------------------------------
  // Counter-read has its own path, so it never waits for model traffic
  always_ff @(posedge clk) begin
    if (rst) begin
      pmc_ack   <= 1'b0;
      pmc_fault <= 1'b0;
      pmc_rdata <= COUNT_RST;
    end else begin
      pmc_ack   <= pmc_ok;
      pmc_fault <= pmc_bad;
      pmc_rdata <= pmc_ok ? pmc_rd_mux : COUNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      msr_ack   <= 1'b0;
      msr_fault <= 1'b0;
      msr_rdata <= COUNT_RST;
      irq_req   <= 1'b0;
    end else begin
      msr_ack   <= msr_ok;
      msr_fault <= msr_bad;
      msr_rdata <= (msr_ok & ~msr_wr) ? msr_rd_mux : COUNT_RST;
      irq_req   <= |ovf_v;
    end
  end
endmodule // decu_top

// [core/decu_pkg.sv]
// Shared constants for the dual event counter unit
// How it works
// - Nonzero threshold: add one when count meets it
// - Zero threshold: add the full per-cycle count, or one per rising edge when edge flag set
// - Permit flag set: counter-read instruction allowed at any level
// - Permit flag clear: counter-read only at level 0
// - Counter-read answers without waiting on other traffic
// - Model register access only at level 0
// - Counter write: low 32 bits, sign-extend bit 31
// - Counting starts right after enable write
// - Enable clear or both setups zero stops both
// - Second setup all zero stops only second counter
// - Overflow with interrupt flag raises interrupt request
// - Two independent 40-bit counters, events or durations
// - User/kernel qualifiers gate counting by privilege level
// - Global enable at bit 22 of first setup
// - Invert flag flips the threshold comparison
package decu_pkg;
  // ----------------------------------------------------------------
  // Widths and default sizes
  // ----------------------------------------------------------------
  localparam int CNT_W        = 40;
  localparam int CFG_W        = 32;
  localparam int WR_W         = 32;
  localparam int DEF_EV_NUM   = 4;
  localparam int DEF_EV_CNT_W = 3;
  // ----------------------------------------------------------------
  // Setup register field positions
  // ----------------------------------------------------------------
  localparam int EVSEL_LSB    = 0;
  localparam int EVSEL_W      = 8;
  localparam int USR_BIT      = 16;
  localparam int OS_BIT       = 17;
  localparam int EDGE_BIT     = 18;
  localparam int INT_BIT      = 20;
  localparam int EN_BIT       = 22;
  localparam int INV_BIT      = 23;
  localparam int THR_LSB      = 24;
  localparam int THR_W        = 8;
  localparam int SIGN_BIT     = 31;
  // ----------------------------------------------------------------
  // Register selector codes on the model register port
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_SETUP_ZERO = 2'h0;
  localparam logic [1:0] SEL_SETUP_ONE  = 2'h1;
  localparam logic [1:0] SEL_COUNT_ZERO = 2'h2;
  localparam logic [1:0] SEL_COUNT_ONE  = 2'h3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] SETUP_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] COUNT_RST = 40'h00_0000_0000;
endpackage

// [core/decu_ch_if.sv]
// Per-channel signals between the unit top and one counter channel
interface decu_ch_if;
  import decu_pkg::*;
  logic [CFG_W-1:0] cfg;
  logic             run;
  logic             cpl_zero;
  logic             wr;
  logic [WR_W-1:0]  wr_data;
  logic [CNT_W-1:0] value;
  logic             ovf;
  modport top  (output cfg, run, cpl_zero, wr, wr_data, input value, ovf);
  modport chan (input cfg, run, cpl_zero, wr, wr_data, output value, ovf);
endinterface

// [core/decu_channel.sv]
// One 40-bit event or duration counter channel
module decu_channel
  import decu_pkg::*;
#(
  parameter int EV_NUM   = DEF_EV_NUM,
  parameter int EV_CNT_W = DEF_EV_CNT_W
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [EV_NUM*EV_CNT_W-1:0] ev_counts,
  decu_ch_if.chan                        ch
);
  localparam int IDX_W = $clog2(EV_NUM);

  initial begin
    if (EV_NUM < 2 || EV_NUM > 256 || EV_CNT_W < 1 || EV_CNT_W > THR_W) begin
      $error("decu_channel: unsupported event geometry");
    end
  end

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  logic [EV_CNT_W-1:0] ev_arr [EV_NUM];
  genvar g;
  generate
    for (g = 0; g < EV_NUM; g++) begin : g_unpack
      assign ev_arr[g] = ev_counts[g*EV_CNT_W +: EV_CNT_W];
    end
  endgenerate

  wire [EVSEL_W-1:0]  code    = ch.cfg[EVSEL_LSB +: EVSEL_W];
  wire                code_ok = ({24'h0, code} < 32'(EV_NUM));
  wire [EV_CNT_W-1:0] picked  = code_ok ? ev_arr[code[IDX_W-1:0]] : '0;

  // ----------------------------------------------------------------
  // Qualifiers and threshold
  // ----------------------------------------------------------------
  wire [THR_W-1:0] thr      = ch.cfg[THR_LSB +: THR_W];
  wire             lvl_ok   = (ch.cfg[USR_BIT] & ~ch.cpl_zero)
                            | (ch.cfg[OS_BIT] & ch.cpl_zero);
  wire [THR_W-1:0] picked_w = THR_W'(picked);
  wire             cmp      = (picked_w >= thr) ^ ch.cfg[INV_BIT];
  wire             cond     = (thr != '0) ? cmp : (picked != '0);
  logic            prev_ff;
  // Edge mode counts rising conditions only; back-to-back ones merge
  wire             edge_hit = cond & ~prev_ff;
  wire             one_hit  = ch.cfg[EDGE_BIT] ? edge_hit : cond;
  wire             use_sum  = (thr == '0) & ~ch.cfg[EDGE_BIT];
  wire [CNT_W-1:0] step     = ~(ch.run & lvl_ok) ? '0
                            : use_sum ? CNT_W'(picked)
                            : CNT_W'(one_hit);
  wire [CNT_W:0]   sum      = {1'b0, ch.value} + {1'b0, step};

  logic [CNT_W-1:0] value_ff;
  logic             ovf_ff;
  assign ch.value = value_ff;
  assign ch.ovf   = ovf_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      value_ff <= COUNT_RST;
      ovf_ff   <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      prev_ff <= ch.run & lvl_ok & cond;
      if (ch.wr) begin
        value_ff <= {{(CNT_W-WR_W){ch.wr_data[SIGN_BIT]}}, ch.wr_data};
        ovf_ff   <= 1'b0;
      end else begin
        value_ff <= sum[CNT_W-1:0];
        ovf_ff   <= sum[CNT_W];
      end
    end
  end
endmodule // decu_channel

// [tb/decu_sva.sv]
// Port checks for the dual event counter unit
module decu_sva
  import decu_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [1:0]       cpl,
  input wire logic             user_read_permit,
  input wire logic             msr_req,
  input wire logic             msr_ack,
  input wire logic             msr_fault,
  input wire logic [CNT_W-1:0] msr_rdata,
  input wire logic             pmc_req,
  input wire logic             pmc_ack,
  input wire logic             pmc_fault,
  input wire logic             irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  msr_grant_a: assert property (msr_req && cpl == 2'h0 |=> msr_ack && !msr_fault)
    else $error("msr access not acknowledged");
  msr_deny_a: assert property (msr_req && cpl != 2'h0 |=> msr_fault && !msr_ack)
    else $error("msr access not refused");
  msr_quiet_a: assert property (!msr_req |=> !msr_ack && !msr_fault)
    else $error("msr answer without request");
  rdata_idle_a: assert property (!msr_ack |-> msr_rdata == 40'h0)
    else $error("msr data outside ack");
  pmc_grant_a: assert property (pmc_req && (user_read_permit || cpl == 2'h0) |=> pmc_ack)
    else $error("counter read not acknowledged");
  pmc_deny_a: assert property (pmc_req && !user_read_permit && cpl != 2'h0 |=> pmc_fault)
    else $error("counter read not refused");
  pmc_quiet_a: assert property (!pmc_req |=> !pmc_ack && !pmc_fault)
    else $error("counter read answer without request");
  irq_pulse_a: assert property (irq_req |=> !irq_req)
    else $error("interrupt request longer than one cycle");
endmodule // decu_sva
bind decu_top decu_sva decu_sva_i (.clk(clk), .rst(rst), .cpl(cpl),
  .user_read_permit(user_read_permit), .msr_req(msr_req), .msr_ack(msr_ack),
  .msr_fault(msr_fault), .msr_rdata(msr_rdata), .pmc_req(pmc_req), .pmc_ack(pmc_ack),
  .pmc_fault(pmc_fault), .irq_req(irq_req));

// [tb/decu_src_model.sv]
// Pipeline event sources: per-cycle counts, zero when idle
module decu_src_model;
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ev_counts = 12'h000;
endmodule // decu_src_model

// [tb/tb_decu_top.sv]
// Self-checking bench for the dual event counter unit
module tb_decu_top;
  import decu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0, rst = 1'b1, user_read_permit = 1'b0, flt;
  logic             msr_req = 1'b0, msr_wr = 1'b0, pmc_req = 1'b0, pmc_idx = 1'b0;
  logic [1:0]       cpl = 2'h0, msr_sel = 2'h0;
  logic [WR_W-1:0]  msr_wdata = 32'h0;
  logic             msr_ack, msr_fault, pmc_ack, pmc_fault, irq_req;
  logic [CNT_W-1:0] msr_rdata, pmc_rdata, rd;
  int               errors = 0, total_checks = 0;
  always #10 clk = ~clk;
  decu_src_model decu_src_model_i ();
  decu_top decu_top_i (.clk(clk), .rst(rst), .cpl(cpl), .user_read_permit(user_read_permit),
    .ev_counts(decu_src_model_i.ev_counts), .msr_req(msr_req), .msr_wr(msr_wr),
    .msr_sel(msr_sel), .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_fault(msr_fault),
    .msr_rdata(msr_rdata), .pmc_req(pmc_req), .pmc_idx(pmc_idx), .pmc_ack(pmc_ack),
    .pmc_fault(pmc_fault), .pmc_rdata(pmc_rdata), .irq_req(irq_req));
  task automatic chk(input logic [CNT_W-1:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Entered at a falling edge; a pulse request, answer one cycle later
  task automatic acc(input logic p, w, input logic [1:0] s, input logic [31:0] d);
    msr_req = !p;
    pmc_req = p;
    msr_wr = w;
    msr_sel = s;
    pmc_idx = s[0];
    msr_wdata = d;
    @(negedge clk);
    msr_req = 1'b0;
    pmc_req = 1'b0;
    // Answer stands one cycle only; one idle cycle keeps pulses apart
    for (int i = 0; i < 4; i++) begin
      if ((p ? pmc_ack | pmc_fault : msr_ack | msr_fault) === 1'b1) begin
        rd = p ? pmc_rdata : msr_rdata;
        flt = p ? pmc_fault : msr_fault;
        @(negedge clk);
        return;
      end
      @(negedge clk);
    end
    errors++;
    conclude();
  endtask
  task automatic feed(input logic [11:0] p, input logic [1:0] c);
    decu_src_model_i.ev_counts = p;
    cpl = c;
    @(negedge clk);
  endtask
  // Counter zero counts three cycles at level 1, then is read back
  task automatic run(input logic [31:0] cfg, input logic [11:0] a, b, c, input int exp);
    acc(0, 1, 2'h0, cfg);
    acc(0, 1, 2'h2, 32'h0);
    feed(a, 2'h1);
    feed(b, 2'h1);
    feed(c, 2'h1);
    feed(12'h0, 2'h0);
    acc(0, 0, 2'h2, 32'h0);
    chk(rd, CNT_W'(exp));
  endtask
  task automatic sc_regs;
    for (int s = 0; s < 4; s++) begin
      acc(0, 0, s[1:0], 32'h0);
      chk(rd, 40'h0);
    end
    acc(0, 1, 2'h2, 32'h8000_0001);
    acc(0, 0, 2'h2, 32'h0);
    chk(rd, 40'hff_8000_0001);
    acc(0, 1, 2'h3, 32'h7fff_fffe);
    acc(0, 0, 2'h3, 32'h0);
    chk(rd, 40'h00_7fff_fffe);
    cpl = 2'h3;
    acc(0, 1, 2'h3, 32'h0);
    chk({39'h0, flt}, 40'h1);
    cpl = 2'h0;
    acc(0, 0, 2'h3, 32'h0);
    chk(rd, 40'h00_7fff_fffe);
  endtask
  task automatic sc_read;
    cpl = 2'h3;
    acc(1, 0, 2'h0, 32'h0);
    chk({39'h0, flt}, 40'h1);
    user_read_permit = 1'b1;
    acc(1, 0, 2'h0, 32'h0);
    chk(rd, 40'h9);
    cpl = 2'h0;
  endtask
  task automatic sc_second;
    acc(0, 1, 2'h1, 32'h0001_0001);
    acc(0, 1, 2'h2, 32'h0);
    acc(0, 1, 2'h3, 32'h0);
    feed(12'h009, 2'h1);
    feed(12'h0, 2'h0);
    acc(0, 1, 2'h1, 32'h0);
    feed(12'h009, 2'h1);
    feed(12'h0, 2'h0);
    acc(0, 0, 2'h3, 32'h0);
    chk(rd, 40'h1);
    acc(0, 0, 2'h2, 32'h0);
    chk(rd, 40'h2);
  endtask
  task automatic sc_wrap;
    acc(0, 1, 2'h0, 32'h0051_0000);
    acc(0, 1, 2'h2, 32'hffff_ffff);
    feed(12'h001, 2'h1);
    feed(12'h0, 2'h0);
    chk({39'h0, irq_req}, 40'h1);
    @(negedge clk);
    chk({39'h0, irq_req}, 40'h0);
    acc(0, 0, 2'h2, 32'h0);
    chk(rd, 40'h0);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    sc_regs();
    run(32'h0041_0000, 12'h003, 12'h003, 12'h003, 9);
    sc_read();
    run(32'h0241_0000, 12'h001, 12'h002, 12'h003, 2);
    run(32'h02c1_0000, 12'h001, 12'h002, 12'h003, 1);
    run(32'h0042_0000, 12'h003, 12'h003, 12'h003, 0);
    run(32'h0001_0000, 12'h003, 12'h003, 12'h003, 0);
    run(32'h0041_0005, 12'h003, 12'h003, 12'h003, 0);
    run(32'h0041_0001, 12'h008, 12'h010, 12'h001, 3);
    run(32'h0045_0000, 12'h003, 12'h000, 12'h003, 2);
    sc_second();
    sc_wrap();
    conclude();
  end
endmodule // tb_decu_top
